// *** rtl/pil_latch_bit.v ***
// One request latch: hardware set, software clear, acceptance clear.
// Assumes all inputs come from logic on clk_in.
`timescale 1ns/1ps
`default_nettype none

module pil_latch_bit #(
   parameter CLEAR_WINS = 0
) (
   // Clock and reset
   input  wire clk_in,
   input  wire rst_b_in,
   input  wire ce_in,
   // Control
   input  wire set_in,
   input  wire sw_clr_in,
   input  wire acc_clr_in,
   // State
   output reg  latch_out
);

   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         latch_out <= 1'b0;
      end else if (ce_in) begin
         // Acceptance clear beats a new request only where allowed
         if (CLEAR_WINS != 0 && acc_clr_in) begin
            latch_out <= 1'b0;
         end else if (set_in) begin
            latch_out <= 1'b1;
         end else if (sw_clr_in || acc_clr_in) begin
            latch_out <= 1'b0;
         end
      end
   end

endmodule // pil_latch_bit

`default_nettype wire

// *** rtl/pil_map.vh ***
// Constants of the interrupt latch unit: special-function offsets,
// field positions, reset values and sequence timing.
// Assumes inclusion by bare name from the design files.
`ifndef PIL_MAP_VH
`define PIL_MAP_VH

// ----------------------------------------
// Special-function offsets
// ----------------------------------------
`define PIL_ADDR_LATCH_EXT  8'h2e
`define PIL_ADDR_LATCH_LOW  8'h3c
`define PIL_ADDR_LATCH_HIGH 8'h3d
`define PIL_ADDR_ENABLE_EXT 8'h2c
`define PIL_ADDR_ENABLE_LOW 8'h3a
`define PIL_ADDR_ENABLE_HI  8'h3b

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PIL_IMF_BIT         0
`define PIL_SRC_FIRST       2
`define PIL_SRC_LAST        23
`define PIL_NMI_ATRAP       2
`define PIL_NMI_WDT         3
`define PIL_MASK_FIRST      4
`define PIL_IDX_CONV_DONE   15
`define PIL_IDX_HIGH_FIRST  16
`define PIL_LATCH_RST       22'h000000
`define PIL_ENABLE_RST      20'h00000
`define PIL_IMF_RST         1'b0
`define PIL_RDATA_RST       8'h00

// ----------------------------------------
// Vectors
// ----------------------------------------
`define PIL_VEC_RESET       16'hfffe
`define PIL_VEC_TRAP        16'hfffc
`define PIL_VEC_ATRAP       16'hfffa
`define PIL_VEC_WDT         16'hfff8
`define PIL_VEC_LOW_BASE    16'hfff6
`define PIL_VEC_HIGH_BASE   16'hffbe

// ----------------------------------------
// Acceptance sequence timing
// ----------------------------------------
`define PIL_MCYC_CLKS       4
`define PIL_ACC_MCYC        8
`define PIL_ACC_CLKS        (`PIL_ACC_MCYC * `PIL_MCYC_CLKS)
`define PIL_CNT_W           6

`endif

// *** rtl/pil_unit.v ***
// Prioritized interrupt latch unit: request latches, enables, fixed
// priority selection, vector output and acceptance sequence.
// Assumes the CPU core and sources run on clk_in; pins are asynchronous.
//
// Function
// - Serve 24 sources beyond reset; four non-maskable, rest maskable.
// - A source request sets its latch, asking the CPU when enabled.
// - Simultaneous requests accepted in fixed order, priority 5 to 24.
// - Non-maskable sources share one level just below reset.
// - Maskable source needs master enable and its own enable flag.
// - First pin source also needs its separate pin enable.
// - Software and illegal-opcode traps have no latch, share FFFC; reset FFFE.
// - Address trap uses latch 2, FFFA; watchdog latch 3, FFF8; non-maskable.
// - Maskable source n uses latch n, enable n; vectors descend by two from FFF6 (4-15) and from FFBE (16-23).
// - Every source except the two traps has a request latch.
// - Accepted source latch clears at acceptance without software.
// - Reset forces every request latch to zero.
// - Latches at 2E, 3C, 3D; readable, individually cleared by writing zero.
// - A software write never sets a latch.
// - Converter-done latch may clear unserved when lower source is accepted.
// - Nested service works under fixed priority once master enable returns.
// - Acceptance stacks master enable, then clears it; return restores it.
// - Acceptance takes 8 machine cycles after the current instruction.
// - Master enable is bit 0 of enable word 3A, reset to zero.
// - Non-maskable sources are accepted regardless of any enable.
`timescale 1ns/1ps
`default_nettype none
`include "pil_map.vh"

module pil_unit (
   // Clock, reset, enable
   input  wire        clk_in,
   input  wire        rst_b_in,
   input  wire        ce_in,
   // Special-function access
   input  wire [7:0]  sfr_addr_in,
   input  wire        sfr_rd_in,
   input  wire        sfr_wr_in,
   input  wire [7:0]  sfr_wdata_in,
   output reg  [7:0]  sfr_rdata_out,
   // Request sources
   input  wire [23:2] src_req_in,
   input  wire [4:0]  ext_pin_in,
   input  wire        ext_pin0_enable_in,
   input  wire        software_trap_in,
   input  wire        illegal_opcode_trap_in,
   // CPU core
   input  wire        instr_done_in,
   input  wire        return_in,
   input  wire        return_imf_in,
   output wire        irq_req_out,
   output reg  [15:0] vector_out,
   output reg         imf_stacked_out,
   output wire        acc_busy_out,
   output wire        master_irq_enable_out
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_SEQ  = 2'b10;
   localparam integer ACC_CLKS = `PIL_ACC_CLKS;

   reg  [1:0]              state_r;
   reg  [1:0]              state_nxt;
   reg  [`PIL_CNT_W-1:0]   cnt_r;
   reg                     master_irq_enable_r;
   reg  [23:4]             source_enable_flag_r;
   reg  [4:0]              pin_s1_r;
   reg  [4:0]              pin_s2_r;
   reg  [4:0]              pin_s3_r;
   wire [23:2]             request_latch;
   wire [23:2]             hw_set;
   wire [23:2]             sw_clr;
   wire [23:2]             acc_clr;
   wire [4:0]              pin_rise;
   wire [23:2]             eligible;
   wire                    accept;
   reg                     sel_any;
   reg                     sel_trap;
   reg  [4:0]              sel_idx;
   reg  [15:0]             sel_vec;
   integer                 i;

   // ----------------------------------------
   // Pin synchronisers and edge detect
   // ----------------------------------------
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         pin_s1_r <= 5'h00;
         pin_s2_r <= 5'h00;
         pin_s3_r <= 5'h00;
      end else if (ce_in) begin
         pin_s1_r <= ext_pin_in;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   assign pin_rise = pin_s2_r & ~pin_s3_r;

   // External pins land on latches 4, 6, 8, 12 and 23
   assign hw_set = src_req_in
                 | {pin_rise[4], 10'h000, pin_rise[3], 3'h0, pin_rise[2], 1'b0,
                    pin_rise[1], 1'b0, pin_rise[0], 2'h0};

   // ----------------------------------------
   // Latch clears
   // ----------------------------------------
   // Zero clears, one leaves the latch alone; no write can set
   assign sw_clr = !sfr_wr_in ? 22'h000000 :
                   (sfr_addr_in == `PIL_ADDR_LATCH_LOW)  ? {16'h0000, ~sfr_wdata_in[7:2]} :
                   (sfr_addr_in == `PIL_ADDR_LATCH_HIGH) ? {8'h00, ~sfr_wdata_in, 6'h00} :
                   (sfr_addr_in == `PIL_ADDR_LATCH_EXT)  ? {~sfr_wdata_in, 14'h0000} :
                   22'h000000;

   genvar g;
   generate
      for (g = `PIL_SRC_FIRST; g <= `PIL_SRC_LAST; g = g + 1) begin : gen_latch
         // Converter request landing while a lower source is taken is lost
         assign acc_clr[g] = accept && !sel_trap &&
                             ((sel_idx == g) ||
                              (g == `PIL_IDX_CONV_DONE && sel_idx > g && hw_set[g]));
         pil_latch_bit #(
            .CLEAR_WINS ((g == `PIL_IDX_CONV_DONE) ? 1 : 0)
         ) u_latch (
            .clk_in     (clk_in),
            .rst_b_in   (rst_b_in),
            .ce_in      (ce_in),
            .set_in     (hw_set[g]),
            .sw_clr_in  (sw_clr[g]),
            .acc_clr_in (acc_clr[g]),
            .latch_out  (request_latch[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Eligibility
   // ----------------------------------------
   // Non-maskable latches ignore every enable
   assign eligible[3:2] = request_latch[3:2];
   assign eligible[4] = request_latch[4] & master_irq_enable_r
                      & source_enable_flag_r[4] & ext_pin0_enable_in;
   assign eligible[23:5] = request_latch[23:5] & source_enable_flag_r[23:5]
                         & {19{master_irq_enable_r}};

   // ----------------------------------------
   // Priority selection
   // ----------------------------------------
   always @* begin
      sel_any  = 1'b0;
      sel_trap = 1'b0;
      sel_idx  = 5'h00;
      sel_vec  = `PIL_VEC_RESET;
      // Lowest index wins; loop runs downward so the last hit stays
      for (i = `PIL_SRC_LAST; i >= `PIL_MASK_FIRST; i = i - 1) begin
         if (eligible[i]) begin
            sel_any = 1'b1;
            sel_idx = i[4:0];
            if (i >= `PIL_IDX_HIGH_FIRST) begin
               sel_vec = `PIL_VEC_HIGH_BASE - {10'h000, i[4:0] - 5'h10, 1'b0};
            end else begin
               sel_vec = `PIL_VEC_LOW_BASE - {10'h000, i[4:0] - 5'h04, 1'b0};
            end
         end
      end
      // One shared level: fixed pick order among non-maskables, not a rank
      if (eligible[`PIL_NMI_WDT]) begin
         sel_any = 1'b1;
         sel_idx = 5'h03;
         sel_vec = `PIL_VEC_WDT;
      end
      if (eligible[`PIL_NMI_ATRAP]) begin
         sel_any = 1'b1;
         sel_idx = 5'h02;
         sel_vec = `PIL_VEC_ATRAP;
      end
      if (software_trap_in || illegal_opcode_trap_in) begin
         sel_any  = 1'b1;
         sel_trap = 1'b1;
         sel_idx  = 5'h00;
         sel_vec  = `PIL_VEC_TRAP;
      end
   end

   // ----------------------------------------
   // Acceptance sequence
   // ----------------------------------------
   // Taken only at an instruction boundary while idle
   assign accept       = ce_in && (state_r == ST_IDLE) && sel_any && instr_done_in;
   assign irq_req_out  = (state_r == ST_IDLE) && sel_any;
   assign acc_busy_out = (state_r == ST_SEQ);
   assign master_irq_enable_out = master_irq_enable_r;

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (accept) begin
               state_nxt = ST_SEQ;
            end
         end
         ST_SEQ: begin
            if (cnt_r == `PIL_CNT_W'd1) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_r <= ST_IDLE;
         cnt_r   <= {`PIL_CNT_W{1'b0}};
      end else if (ce_in) begin
         state_r <= state_nxt;
         if (accept) begin
            cnt_r <= ACC_CLKS[`PIL_CNT_W-1:0];
         end else if (cnt_r != {`PIL_CNT_W{1'b0}}) begin
            cnt_r <= cnt_r - `PIL_CNT_W'd1;
         end
      end
   end

   // Vector follows the best request until one is taken, then holds
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         vector_out <= `PIL_VEC_RESET;
      end else if (ce_in && state_r == ST_IDLE) begin
         vector_out <= sel_vec;
      end
   end

   // ----------------------------------------
   // Master enable and per-source enables
   // ----------------------------------------
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         master_irq_enable_r  <= `PIL_IMF_RST;
         source_enable_flag_r <= `PIL_ENABLE_RST;
         imf_stacked_out      <= 1'b0;
      end else if (ce_in) begin
         if (sfr_wr_in && sfr_addr_in == `PIL_ADDR_ENABLE_LOW) begin
            source_enable_flag_r[7:4] <= sfr_wdata_in[7:4];
         end
         if (sfr_wr_in && sfr_addr_in == `PIL_ADDR_ENABLE_HI) begin
            source_enable_flag_r[15:8] <= sfr_wdata_in;
         end
         if (sfr_wr_in && sfr_addr_in == `PIL_ADDR_ENABLE_EXT) begin
            source_enable_flag_r[23:16] <= sfr_wdata_in;
         end
         // Acceptance beats a simultaneous software set of the master enable
         if (accept) begin
            imf_stacked_out     <= master_irq_enable_r;
            master_irq_enable_r <= 1'b0;
         end else if (return_in) begin
            master_irq_enable_r <= return_imf_in;
         end else if (sfr_wr_in && sfr_addr_in == `PIL_ADDR_ENABLE_LOW) begin
            master_irq_enable_r <= sfr_wdata_in[`PIL_IMF_BIT];
         end
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Unmapped locations read as zero
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         sfr_rdata_out <= `PIL_RDATA_RST;
      end else if (ce_in && sfr_rd_in) begin
         case (sfr_addr_in)
            `PIL_ADDR_LATCH_LOW:  sfr_rdata_out <= {request_latch[7:2], 2'b00};
            `PIL_ADDR_LATCH_HIGH: sfr_rdata_out <= request_latch[15:8];
            `PIL_ADDR_LATCH_EXT:  sfr_rdata_out <= request_latch[23:16];
            `PIL_ADDR_ENABLE_LOW: sfr_rdata_out <= {source_enable_flag_r[7:4], 3'b000,
                                                    master_irq_enable_r};
            `PIL_ADDR_ENABLE_HI:  sfr_rdata_out <= source_enable_flag_r[15:8];
            `PIL_ADDR_ENABLE_EXT: sfr_rdata_out <= source_enable_flag_r[23:16];
            default:              sfr_rdata_out <= `PIL_RDATA_RST;
         endcase
      end
   end

endmodule // pil_unit

`default_nettype wire

// *** tb/pil_cpu_model.sv ***
// Core model: marks instruction boundaries so pending requests are taken.
// Assumes go_in and slow_in change off the rising edge.
`timescale 1ns/1ps
`default_nettype none
module pil_cpu_model (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   // Bench control
   input  wire logic go_in,
   input  wire logic slow_in,
   // Unit side
   input  wire logic irq_req_in,
   input  wire logic acc_busy_in,
   output var  logic instr_done_out
);
   logic [2:0] wait_r;
   // Slow mode models a long instruction before the boundary
   always @(posedge clk_in) begin
      instr_done_out <= 1'b0;
      if (!rst_b_in || !go_in || acc_busy_in || !irq_req_in) begin
         wait_r <= 3'h0;
      end else if (!instr_done_out && wait_r >= (slow_in ? 3'h3 : 3'h0)) begin
         instr_done_out <= 1'b1;
      end else begin
         wait_r <= wait_r + 3'h1;
      end
   end
endmodule // pil_cpu_model
`default_nettype wire

// *** tb/pil_unit_chk.sv ***
// Checker of the interrupt latch unit, bound to its ports.
// Assumes one clock domain and ce_in held high by the bench.
`timescale 1ns/1ps
`default_nettype none
module pil_unit_chk (
   // Clock, reset and register access
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic        ce_in,
   input wire logic [7:0]  sfr_addr_in,
   input wire logic        sfr_rd_in,
   input wire logic [7:0]  sfr_rdata_out,
   // Requests and core side
   input wire logic [23:2] src_req_in,
   input wire logic        software_trap_in,
   input wire logic        illegal_opcode_trap_in,
   input wire logic        instr_done_in,
   input wire logic        return_in,
   input wire logic        return_imf_in,
   input wire logic        irq_req_out,
   input wire logic [15:0] vector_out,
   input wire logic        imf_stacked_out,
   input wire logic        acc_busy_out,
   input wire logic        master_irq_enable_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   logic [7:0] busy_cnt_r;
   // Counts sequence cycles so its length can be checked at the fall
   always @(posedge clk_in) begin
      if (!rst_b_in || !acc_busy_out) busy_cnt_r <= 8'h00;
      else busy_cnt_r <= busy_cnt_r + 8'h01;
   end
   sequence s_accept;
      irq_req_out && instr_done_in && ce_in && !acc_busy_out;
   endsequence
   sequence s_entry;
      acc_busy_out && !master_irq_enable_out && !irq_req_out;
   endsequence
   accept_start_a: assert property (s_accept |=> s_entry) else $error("no sequence start");
   stack_capture_a: assert property (s_accept |=> imf_stacked_out == $past(master_irq_enable_out))
      else $error("stacked enable wrong");
   busy_length_a: assert property ($fell(acc_busy_out) |-> busy_cnt_r == 8'h20) else $error("bad length");
   busy_quiet_a: assert property (acc_busy_out |-> !irq_req_out) else $error("request during sequence");
   vector_hold_a: assert property (acc_busy_out && $past(acc_busy_out) |-> $stable(vector_out))
      else $error("vector moved");
   nmi_request_a: assert property ((|src_req_in[3:2]) && !acc_busy_out && !instr_done_in
      |=> irq_req_out) else $error("nmi not requested");
   trap_request_a: assert property ((software_trap_in || illegal_opcode_trap_in)
      && !acc_busy_out |-> irq_req_out) else $error("trap not requested");
   return_load_a: assert property (return_in && ce_in && !(irq_req_out && instr_done_in)
      |=> master_irq_enable_out == $past(return_imf_in)) else $error("return not restored");
   unmapped_read_a: assert property (sfr_rd_in && ce_in
      && !(sfr_addr_in inside {8'h2e, 8'h3c, 8'h3d, 8'h2c, 8'h3a, 8'h3b}) |=> sfr_rdata_out == 8'h00)
      else $error("unmapped read nonzero");
   master_read_a: assert property (sfr_rd_in && ce_in && sfr_addr_in == 8'h3a
      |=> sfr_rdata_out[0] == $past(master_irq_enable_out) && sfr_rdata_out[3:1] == 3'h0)
      else $error("master read wrong");
endmodule // pil_unit_chk
bind pil_unit pil_unit_chk u_chk (.clk_in, .rst_b_in, .ce_in, .sfr_addr_in, .sfr_rd_in, .sfr_rdata_out,
   .src_req_in, .software_trap_in, .illegal_opcode_trap_in, .instr_done_in, .return_in, .return_imf_in,
   .irq_req_out, .vector_out, .imf_stacked_out, .acc_busy_out, .master_irq_enable_out);
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the interrupt latch unit with a core model.
// Assumes the unit, its checker and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic [7:0]  sfr_addr_in = 8'h00;
   logic        sfr_rd_in = 1'b0;
   logic        sfr_wr_in = 1'b0;
   logic [7:0]  sfr_wdata_in = 8'h00;
   logic [23:2] src_req_in = 22'h0;
   logic [4:0]  ext_pin_in = 5'h00;
   logic        ext_pin0_enable_in = 1'b0;
   logic        software_trap_in = 1'b0;
   logic        illegal_opcode_trap_in = 1'b0;
   logic        return_in = 1'b0;
   logic        return_imf_in = 1'b0;
   logic        go = 1'b0;
   logic        slow = 1'b0;
   wire         instr_done_in, irq_req_out, imf_stacked_out, acc_busy_out, master_irq_enable_out;
   wire  [7:0]  sfr_rdata_out;
   wire  [15:0] vector_out;
   logic [23:2] m_lat = 22'h0;
   logic [23:4] m_en = 20'h0;
   logic        m_imf = 1'b0;
   logic [7:0]  d;
   integer      seed = 32'h68e0, error_cnt = 0, samples_checked = 0, cyc = 0, r, n, k;

   always #12.5 clk_in = ~clk_in;

   pil_unit uut (.clk_in, .rst_b_in, .ce_in(1'b1), .sfr_addr_in, .sfr_rd_in, .sfr_wr_in, .sfr_wdata_in,
      .sfr_rdata_out, .src_req_in, .ext_pin_in, .ext_pin0_enable_in, .software_trap_in, .illegal_opcode_trap_in,
      .instr_done_in, .return_in, .return_imf_in, .irq_req_out, .vector_out, .imf_stacked_out, .acc_busy_out,
      .master_irq_enable_out);
   pil_cpu_model u_cpu (.clk_in, .rst_b_in, .go_in(go), .slow_in(slow), .irq_req_in(irq_req_out),
      .acc_busy_in(acc_busy_out), .instr_done_out(instr_done_in));

   function automatic integer m_best();
      integer i;
      m_best = 0;
      for (i = 23; i >= 2; i--) begin
         if (m_lat[i] && (i < 4 || m_imf && m_en[i] && (i != 4 || ext_pin0_enable_in))) m_best = i;
      end
   endfunction
   function automatic logic [15:0] m_vec(input integer i);
      if (i < 2) m_vec = 16'hfffc;
      else if (i < 4) m_vec = 16'hfffa - 16'(2 * (i - 2));
      else if (i < 16) m_vec = 16'hfff6 - 16'(2 * (i - 4));
      else m_vec = 16'hffbe - 16'(2 * (i - 16));
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      sfr_addr_in = a;
      sfr_wdata_in = v;
      sfr_wr_in = 1'b1;
      @(negedge clk_in) sfr_wr_in = 1'b0;
      @(negedge clk_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_addr_in = a;
      sfr_rd_in = 1'b1;
      @(negedge clk_in) sfr_rd_in = 1'b0;
      chk(sfr_rdata_out, e);
      @(negedge clk_in);
   endtask
   task automatic chk_lat();
      rd(8'h3c, {m_lat[7:2], 2'b00});
      rd(8'h3d, m_lat[15:8]);
      rd(8'h2e, m_lat[23:16]);
   endtask
   task automatic accept_one();
      integer b;
      b = (software_trap_in || illegal_opcode_trap_in) ? 1 : m_best();
      go = 1'b1;
      k = 0;
      while (acc_busy_out !== 1'b1 && k < 50) begin
         @(negedge clk_in);
         k++;
      end
      go = 1'b0;
      chk(vector_out, m_vec(b));
      chk(master_irq_enable_out, 1'b0);
      chk(imf_stacked_out, m_imf);
      if (b > 1) m_lat[b] = 1'b0;
      software_trap_in = 1'b0;
      illegal_opcode_trap_in = 1'b0;
      k = 0;
      while (acc_busy_out === 1'b1 && k < 40) begin
         @(negedge clk_in);
         k++;
      end
      chk(k[15:0], 16'h0020);
      return_imf_in = m_imf;
      return_in = 1'b1;
      @(negedge clk_in) return_in = 1'b0;
      @(negedge clk_in);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end

   initial begin
      repeat (20) @(negedge clk_in);
      rst_b_in = 1'b1;
      chk_lat();
      for (r = 0; r < 4; r++) begin
         wr(8'h3a, 8'h00);
         src_req_in = 22'($random(seed));
         ext_pin_in = 5'($random(seed));
         @(negedge clk_in);
         m_lat = m_lat | src_req_in;
         src_req_in = 22'h0;
         repeat (5) @(negedge clk_in);
         {m_lat[23], m_lat[12], m_lat[8], m_lat[6], m_lat[4]} =
            {m_lat[23], m_lat[12], m_lat[8], m_lat[6], m_lat[4]} | ext_pin_in;
         ext_pin_in = 5'h00;
         wr(8'h3d, 8'hff);
         d = 8'($random(seed)) | 8'h0c;
         wr(8'h3c, d);
         m_lat[7:2] &= d[7:2];
         d = 8'($random(seed));
         wr(8'h3d, d);
         m_lat[15:8] &= d;
         d = 8'($random(seed));
         wr(8'h2e, d);
         m_lat[23:16] &= d;
         chk_lat();
         m_en = 20'($random(seed));
         m_imf = (r != 0);
         ext_pin0_enable_in = r[1];
         wr(8'h3b, m_en[15:8]);
         wr(8'h2c, m_en[23:16]);
         wr(8'h3a, {m_en[7:4], 3'h0, m_imf});
         rd(8'h3a, {m_en[7:4], 3'h0, m_imf});
         rd(8'h40, 8'h00);
         software_trap_in = (r == 2);
         illegal_opcode_trap_in = (r == 3);
         slow = r[0];
         for (n = 0; n < 30 && (software_trap_in || illegal_opcode_trap_in || m_best() != 0); n++) accept_one();
         chk(irq_req_out, 1'b0);
         chk_lat();
      end
      // Mid-run reset with requests pending
      src_req_in = 22'($random(seed)) | 22'h3;
      @(negedge clk_in);
      src_req_in = 22'h0;
      rst_b_in = 1'b0;
      repeat (2) @(negedge clk_in);
      rst_b_in = 1'b1;
      m_lat = 22'h0;
      chk(vector_out, 16'hfffe);
      chk(master_irq_enable_out, 1'b0);
      chk_lat();
      give_verdict();
   end
endmodule // tb
`default_nettype wire
